// *** rtl/e1_perf_params.svh ***
`ifndef E1_PERF_PARAMS_SVH
`define E1_PERF_PARAMS_SVH

// register offsets inside one channel page
`define OFS_FA_HI        12'h902
`define OFS_FA_LO        12'h903
`define OFS_SEF          12'h904
`define OFS_CRC_HI       12'h905
`define OFS_CRC_LO       12'h906
`define OFS_IRQ_STATUS   12'h9f0
`define OFS_IRQ_ENABLE   12'h9f1
`define OFS_IRQ_CLEAR    12'h9f2

// counter widths
`define FA_CNT_W         16
`define SEF_CNT_W        8
`define CRC_CNT_W        16

// interrupt status bit positions
`define EVT_FA_ERR       0
`define EVT_SEF          1
`define EVT_CRC_ERR      2
`define EVT_FA_SAT       3
`define EVT_SEF_SAT      4
`define EVT_CRC_SAT      5
`define EVT_ORDER        6
`define EVT_NUM          7

// reset values
`define CNT_RESET        16'h0000
`define IRQ_STATUS_RESET 7'h00
`define IRQ_ENABLE_RESET 7'h00
`define RDATA_RESET      8'h00

`endif

// *** rtl/e1_perf_pkg.sv ***
`include "e1_perf_params.svh"

package e1_perf_pkg;

    typedef enum logic [3:0] {
        SEL_NONE       = 4'b0000,
        SEL_FA_HI      = 4'b0001,
        SEL_FA_LO      = 4'b0010,
        SEL_SEF        = 4'b0011,
        SEL_CRC_HI     = 4'b0100,
        SEL_CRC_LO     = 4'b0101,
        SEL_IRQ_STATUS = 4'b0110,
        SEL_IRQ_ENABLE = 4'b0111,
        SEL_IRQ_CLEAR  = 4'b1000
    } reg_sel_t;

    typedef enum logic [0:0] {
        FAS_GOOD    = 1'b0,
        FAS_ONE_BAD = 1'b1
    } sef_state_t;

    typedef struct packed {
        sef_state_t            sef_st;
        logic [`EVT_NUM-1:0]   status;
        logic [`EVT_NUM-1:0]   enable;
        logic [7:0]            rdata;
    } main_state_t;

endpackage : e1_perf_pkg

// *** rtl/perf_cnt_if.sv ***
`timescale 1ns/100ps

interface perf_cnt_if #(
    parameter int W = 16
);
    logic         inc;
    logic         rd_hi;
    logic         rd_lo;
    logic [W-1:0] cnt;
    logic [7:0]   lo_snap;
    logic         snap_vld;
    logic         sat;

    modport ctr  (input inc, input rd_hi, input rd_lo,
                  output cnt, output lo_snap, output snap_vld, output sat);
    modport host (output inc, output rd_hi, output rd_lo,
                  input cnt, input lo_snap, input snap_vld, input sat);
endinterface : perf_cnt_if

// *** rtl/perf_counter.sv ***
`timescale 1ns/100ps
`include "e1_perf_params.svh"

module perf_counter #(
    parameter int W = 16
) (
    input  wire logic clk,
    input  wire logic rst,
    perf_cnt_if.ctr   c
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic [7:0]   snap;
        logic         snap_vld;
        logic         sat;
    } ctr_state_t;

    localparam logic [W-1:0] CNT_MAX  = {W{1'b1}};
    localparam logic [W-1:0] CNT_ZERO = W'(`CNT_RESET);
    localparam logic [W-1:0] CNT_ONE  = W'(1);

    ctr_state_t   s_q;
    ctr_state_t   s_d;
    logic [W-1:0] base;

    always_comb begin
        s_d     = s_q;
        s_d.sat = 1'b0;
        base    = s_q.cnt;
        if (c.rd_hi) begin
            // upper read freezes the low byte and restarts from zero
            s_d.snap     = s_q.cnt[7:0];
            s_d.snap_vld = (W > 8);
            base         = CNT_ZERO;
        end else if (c.rd_lo) begin
            // lower read without a prior upper read clears nothing
            s_d.snap_vld = 1'b0;
        end
        if (c.inc) begin
            // an event in the read cycle counts into the new period
            if (base != CNT_MAX) begin
                s_d.cnt = base + CNT_ONE;
                s_d.sat = ((base + CNT_ONE) == CNT_MAX);
            end else begin
                s_d.cnt = base;
            end
        end else begin
            s_d.cnt = base;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign c.cnt      = s_q.cnt;
    assign c.lo_snap  = s_q.snap;
    assign c.snap_vld = s_q.snap_vld;
    assign c.sat      = s_q.sat;

endmodule : perf_counter

// *** rtl/e1_rx_perf_error_counters.sv ***
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`include "e1_perf_params.svh"

// Function
// - count errored frame alignment words in a 16-bit counter since last read
// - each 16-bit counter is read as an upper byte and a lower byte
// - reading the upper byte clears a 16-bit counter so counting restarts from zero
// - count severely errored frames in an 8-bit counter since last read
// - two consecutive errored alignment words without loss of frame make one event
// - the severely errored frame counter clears when it is read
// - count CRC-4 block errors in a 16-bit counter since last read
module e1_rx_perf_error_counters #(
    parameter logic [3:0] CHAN_ID = 4'h0
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    input  wire logic        fas_strobe,
    input  wire logic        fas_err,
    input  wire logic        lof,
    input  wire logic        crc4_err,
    output logic             irq
);

    e1_perf_pkg::main_state_t s_q;
    e1_perf_pkg::main_state_t s_d;
    e1_perf_pkg::reg_sel_t    sel;

    logic                     chan_hit;
    logic [11:0]              ofs;
    logic                     fa_inc;
    logic                     sef_inc;
    logic                     crc_inc;
    logic                     rd_fa_hi;
    logic                     rd_fa_lo;
    logic                     rd_sef;
    logic                     rd_crc_hi;
    logic                     rd_crc_lo;
    logic                     order_fault;
    logic [`EVT_NUM-1:0]      events;
    logic [`EVT_NUM-1:0]      clr_mask;

    perf_cnt_if #(.W(`FA_CNT_W))  fa_if ();
    perf_cnt_if #(.W(`SEF_CNT_W)) sef_if ();
    perf_cnt_if #(.W(`CRC_CNT_W)) crc_if ();

    // ------------------------------------------------------------------
    // address decode: upper nibble selects the channel page
    // ------------------------------------------------------------------
    assign chan_hit = (addr[15:12] == CHAN_ID);
    assign ofs      = addr[11:0];

    always_comb begin
        sel = e1_perf_pkg::SEL_NONE;
        if (chan_hit) begin
            case (ofs)
                `OFS_FA_HI: begin
                    sel = e1_perf_pkg::SEL_FA_HI;
                end
                `OFS_FA_LO: begin
                    sel = e1_perf_pkg::SEL_FA_LO;
                end
                `OFS_SEF: begin
                    sel = e1_perf_pkg::SEL_SEF;
                end
                `OFS_CRC_HI: begin
                    sel = e1_perf_pkg::SEL_CRC_HI;
                end
                `OFS_CRC_LO: begin
                    sel = e1_perf_pkg::SEL_CRC_LO;
                end
                `OFS_IRQ_STATUS: begin
                    sel = e1_perf_pkg::SEL_IRQ_STATUS;
                end
                `OFS_IRQ_ENABLE: begin
                    sel = e1_perf_pkg::SEL_IRQ_ENABLE;
                end
                `OFS_IRQ_CLEAR: begin
                    sel = e1_perf_pkg::SEL_IRQ_CLEAR;
                end
                default: begin
                    sel = e1_perf_pkg::SEL_NONE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read strobes towards the counters
    // ------------------------------------------------------------------
    assign rd_fa_hi  = rd && (sel == e1_perf_pkg::SEL_FA_HI);
    assign rd_fa_lo  = rd && (sel == e1_perf_pkg::SEL_FA_LO);
    assign rd_sef    = rd && (sel == e1_perf_pkg::SEL_SEF);
    assign rd_crc_hi = rd && (sel == e1_perf_pkg::SEL_CRC_HI);
    assign rd_crc_lo = rd && (sel == e1_perf_pkg::SEL_CRC_LO);

    // lower byte read that was not preceded by its upper byte read
    assign order_fault = (rd_fa_lo && !fa_if.snap_vld) || (rd_crc_lo && !crc_if.snap_vld);

    // ------------------------------------------------------------------
    // event sources from the receive framer
    // ------------------------------------------------------------------
    assign fa_inc  = fas_strobe && fas_err;
    assign crc_inc = crc4_err;

    always_comb begin
        sef_inc = 1'b0;
        case (s_q.sef_st)
            e1_perf_pkg::FAS_GOOD: begin
                sef_inc = 1'b0;
            end
            e1_perf_pkg::FAS_ONE_BAD: begin
                // second errored word in a row, framer still in frame
                sef_inc = fas_strobe && fas_err && !lof;
            end
            default: begin
                sef_inc = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // counter hookup
    // ------------------------------------------------------------------
    assign fa_if.inc    = fa_inc;
    assign fa_if.rd_hi  = rd_fa_hi;
    assign fa_if.rd_lo  = rd_fa_lo;

    assign sef_if.inc   = sef_inc;
    assign sef_if.rd_hi = rd_sef;
    assign sef_if.rd_lo = 1'b0;

    assign crc_if.inc   = crc_inc;
    assign crc_if.rd_hi = rd_crc_hi;
    assign crc_if.rd_lo = rd_crc_lo;

    perf_counter #(.W(`FA_CNT_W)) u_fa_cnt (
        .clk (clk),
        .rst (rst),
        .c   (fa_if.ctr)
    );

    perf_counter #(.W(`SEF_CNT_W)) u_sef_cnt (
        .clk (clk),
        .rst (rst),
        .c   (sef_if.ctr)
    );

    perf_counter #(.W(`CRC_CNT_W)) u_crc_cnt (
        .clk (clk),
        .rst (rst),
        .c   (crc_if.ctr)
    );

    // ------------------------------------------------------------------
    // interrupt events
    // ------------------------------------------------------------------
    always_comb begin
        events               = '0;
        events[`EVT_FA_ERR]  = fa_inc;
        events[`EVT_SEF]     = sef_inc;
        events[`EVT_CRC_ERR] = crc_inc;
        events[`EVT_FA_SAT]  = fa_if.sat;
        events[`EVT_SEF_SAT] = sef_if.sat;
        events[`EVT_CRC_SAT] = crc_if.sat;
        events[`EVT_ORDER]   = order_fault;
    end

    assign clr_mask = (wr && (sel == e1_perf_pkg::SEL_IRQ_CLEAR)) ? wdata[`EVT_NUM-1:0] : '0;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;

        // consecutive errored alignment word tracker
        case (s_q.sef_st)
            e1_perf_pkg::FAS_GOOD: begin
                if (fas_strobe && fas_err && !lof) begin
                    s_d.sef_st = e1_perf_pkg::FAS_ONE_BAD;
                end
            end
            e1_perf_pkg::FAS_ONE_BAD: begin
                // a counted pair starts a fresh pair; out of frame restarts too
                if (lof || fas_strobe) begin
                    s_d.sef_st = e1_perf_pkg::FAS_GOOD;
                end
            end
            default: begin
                s_d.sef_st = e1_perf_pkg::FAS_GOOD;
            end
        endcase

        // sticky status: a new event beats a clear in the same cycle
        s_d.status = (s_q.status & ~clr_mask) | events;

        if (wr && (sel == e1_perf_pkg::SEL_IRQ_ENABLE)) begin
            s_d.enable = wdata[`EVT_NUM-1:0];
        end

        // read data stand only in the cycle after the strobe
        s_d.rdata = `RDATA_RESET;
        if (rd) begin
            case (sel)
                e1_perf_pkg::SEL_FA_HI: begin
                    s_d.rdata = fa_if.cnt[15:8];
                end
                e1_perf_pkg::SEL_FA_LO: begin
                    s_d.rdata = fa_if.snap_vld ? fa_if.lo_snap : fa_if.cnt[7:0];
                end
                e1_perf_pkg::SEL_SEF: begin
                    s_d.rdata = sef_if.cnt;
                end
                e1_perf_pkg::SEL_CRC_HI: begin
                    s_d.rdata = crc_if.cnt[15:8];
                end
                e1_perf_pkg::SEL_CRC_LO: begin
                    s_d.rdata = crc_if.snap_vld ? crc_if.lo_snap : crc_if.cnt[7:0];
                end
                e1_perf_pkg::SEL_IRQ_STATUS: begin
                    s_d.rdata = {1'b0, s_q.status};
                end
                e1_perf_pkg::SEL_IRQ_ENABLE: begin
                    s_d.rdata = {1'b0, s_q.enable};
                end
                default: begin
                    s_d.rdata = `RDATA_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q.sef_st <= e1_perf_pkg::FAS_GOOD;
            s_q.status <= `IRQ_STATUS_RESET;
            s_q.enable <= `IRQ_ENABLE_RESET;
            s_q.rdata  <= `RDATA_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign irq   = |(s_q.status & s_q.enable);

endmodule : e1_rx_perf_error_counters

// *** sim/e1_perf_monitor.sv ***
`timescale 1ns/100ps

module e1_perf_monitor #(
    parameter logic [3:0] CHAN_ID = 4'h0
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [15:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata,
    input wire logic        fas_strobe,
    input wire logic        fas_err,
    input wire logic        lof,
    input wire logic        crc4_err,
    input wire logic        irq
);
    localparam logic [15:0] FA_HI  = {CHAN_ID, 12'h902};
    localparam logic [15:0] FA_LO  = {CHAN_ID, 12'h903};
    localparam logic [15:0] SEF    = {CHAN_ID, 12'h904};
    localparam logic [15:0] CRC_HI = {CHAN_ID, 12'h905};
    localparam logic [15:0] IEN    = {CHAN_ID, 12'h9f1};
    localparam logic [15:0] ICLR   = {CHAN_ID, 12'h9f2};
    logic       fe;
    logic [6:0] en_q;

    assign fe = fas_strobe & fas_err;

    // shadow of the interrupt enable register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_q <= 7'h00;
        end else if (wr && addr == IEN) begin
            en_q <= wdata[6:0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("rdata not zero outside read slot");
    AST_OTHER_CHAN: assert property (rd && addr[15:12] != CHAN_ID |=> rdata == 8'h00)
        else $error("read of other channel returned data");
    AST_UNMAPPED: assert property (rd && (addr[11:0] == 12'h907 || addr == ICLR) |=> rdata == 8'h00)
        else $error("unmapped read returned data");
    AST_SEF_CLEAR: assert property ((rd && addr == SEF && !fas_strobe) ##1 !fas_strobe ##1
        (rd && addr == SEF) |=> rdata == 8'h00)
        else $error("severe frame count not cleared by read");
    AST_FA_CLEAR: assert property ((rd && addr == FA_HI && !fe) ##1 !fe ##1 (rd && addr == FA_LO && !fe)
        ##1 !fe ##1 (rd && addr == FA_HI) ##2 (rd && addr == FA_LO) |=> rdata == 8'h00)
        else $error("alignment count not cleared by read pair");
    AST_CRC_RESTART: assert property ((rd && addr == CRC_HI && !crc4_err) ##1 !crc4_err
        ##1 (rd && addr == CRC_HI) |=> rdata == 8'h00)
        else $error("upper read did not restart crc count");
    AST_IRQ_OFF: assert property (wr && addr == IEN && wdata == 8'h00 |=> !irq)
        else $error("irq high with all sources disabled");
    AST_IRQ_FA: assert property (fe && en_q[0] && !(wr && addr == IEN) |=> irq)
        else $error("alignment error did not raise irq");

    COV_PAIR: cover property ((rd && addr == FA_HI) ##2 (rd && addr == FA_LO));
    COV_SEF: cover property (fe ##[1:3] fe);
    COV_IRQ: cover property ($rose(irq));
endmodule : e1_perf_monitor

bind e1_rx_perf_error_counters e1_perf_monitor #(.CHAN_ID(CHAN_ID)) mon (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .fas_strobe(fas_strobe), .fas_err(fas_err), .lof(lof), .crc4_err(crc4_err), .irq(irq)
);

// *** sim/e1_rx_perf_error_counters_test.sv ***
`timescale 1ns/100ps

module e1_rx_perf_error_counters_test;
    localparam logic [3:0]  CH  = 4'h3;
    localparam logic [15:0] FH  = {CH, 12'h902};
    localparam logic [15:0] FL  = {CH, 12'h903};
    localparam logic [15:0] SE  = {CH, 12'h904};
    localparam logic [15:0] CHI = {CH, 12'h905};
    localparam logic [15:0] CLO = {CH, 12'h906};
    localparam logic [15:0] ST  = {CH, 12'h9f0};
    localparam logic [15:0] EN  = {CH, 12'h9f1};
    localparam logic [15:0] CL  = {CH, 12'h9f2};
    logic        clk, rst, wr, rd, fas_strobe, fas_err, lof, crc4_err, irq;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata;
    int          bad_count, samples_checked;

    e1_rx_perf_error_counters #(.CHAN_ID(CH)) dut (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .fas_strobe(fas_strobe), .fas_err(fas_err), .lof(lof), .crc4_err(crc4_err), .irq(irq)
    );

    always #5 clk = ~clk;

    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    task wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask : wr_reg

    task rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk($sformatf("reg %h", a), {8'h00, rdata}, {8'h00, e});
    endtask : rd_chk

    task fa_ev(input logic e, input logic l, input int n);
        repeat (n) begin
            @(posedge clk);
            fas_strobe <= 1'b1;
            fas_err    <= e;
            lof        <= l;
        end
        @(posedge clk);
        fas_strobe <= 1'b0;
        lof        <= 1'b0;
    endtask : fa_ev

    task crc_ev(input int n);
        repeat (n) begin
            @(posedge clk);
            crc4_err <= 1'b1;
        end
        @(posedge clk);
        crc4_err <= 1'b0;
    endtask : crc_ev

    task automatic t_reset;
        logic [15:0] al[9] = '{ST, FH, FL, SE, CHI, CLO, EN, CL, 16'h5902};
        wr_reg(FH, 8'hff);
        foreach (al[i]) rd_chk(al[i], 8'h00);
        rd_chk({CH, 12'h907}, 8'h00);
        chk("irq", {15'h0, irq}, 16'h0000);
    endtask : t_reset

    task t_fa;
        fa_ev(1'b0, 1'b0, 2);
        fa_ev(1'b1, 1'b0, 3);
        rd_chk(FH, 8'h00);
        rd_chk(FL, 8'h03);
        rd_chk(FH, 8'h00);
        rd_chk(FL, 8'h00);
        rd_chk(SE, 8'h01);
        rd_chk(SE, 8'h00);
    endtask : t_fa

    task t_sef;
        // a clean word disarms the pair tracker left armed by the last odd errored word
        fa_ev(1'b0, 1'b0, 1);
        fa_ev(1'b1, 1'b0, 1);
        fa_ev(1'b1, 1'b1, 1);
        fa_ev(1'b1, 1'b0, 4);
        rd_chk(SE, 8'h02);
        rd_chk(FH, 8'h00);
        rd_chk(FL, 8'h06);
    endtask : t_sef

    task t_crc;
        crc_ev(261);
        rd_chk(CHI, 8'h01);
        rd_chk(CLO, 8'h05);
        crc_ev(3);
        fork
            begin
                rd_chk(CHI, 8'h00);
                rd_chk(CLO, 8'h03);
            end
            begin
                repeat (2) @(posedge clk);
                crc4_err <= 1'b1;
                @(posedge clk);
                crc4_err <= 1'b0;
            end
        join
        rd_chk(CHI, 8'h00);
        rd_chk(CLO, 8'h01);
    endtask : t_crc

    task t_order;
        wr_reg(CL, 8'h7f);
        crc_ev(2);
        rd_chk(CLO, 8'h02);
        rd_chk(ST, 8'h44);
        rd_chk(CHI, 8'h00);
        rd_chk(CLO, 8'h02);
    endtask : t_order

    task t_irq;
        wr_reg(CL, 8'h7f);
        wr_reg(EN, 8'h01);
        chk("irq", {15'h0, irq}, 16'h0000);
        fa_ev(1'b1, 1'b0, 1);
        @(negedge clk);
        chk("irq", {15'h0, irq}, 16'h0001);
        wr_reg(EN, 8'h00);
        chk("irq", {15'h0, irq}, 16'h0000);
        wr_reg(EN, 8'h01);
        rd_chk(EN, 8'h01);
        rd_chk(ST, 8'h01);
        wr_reg(CL, 8'h01);
        chk("irq", {15'h0, irq}, 16'h0000);
    endtask : t_irq

    task t_sat;
        fa_ev(1'b1, 1'b0, 520);
        crc_ev(65540);
        rd_chk(SE, 8'hff);
        rd_chk(FH, 8'h02);
        rd_chk(FL, 8'h09);
        rd_chk(CHI, 8'hff);
        rd_chk(CHI, 8'h00);
        rd_chk(CLO, 8'h00);
        rd_chk(ST, 8'h37);
    endtask : t_sat

    initial begin
        clk             = 1'b0;
        rst             = 1'b1;
        wr              = 1'b0;
        rd              = 1'b0;
        addr            = 16'h0000;
        wdata           = 8'h00;
        fas_strobe      = 1'b0;
        fas_err         = 1'b0;
        lof             = 1'b0;
        crc4_err        = 1'b0;
        bad_count       = 0;
        samples_checked = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_fa;
        t_sef;
        t_crc;
        t_order;
        t_irq;
        t_sat;
        report_and_stop;
    end

    // watchdog against a hung run
    initial begin
        #1000000;
        bad_count++;
        report_and_stop;
    end
endmodule : e1_rx_perf_error_counters_test
